// ### hw/ccpm_pkg.sv
package ccpm_pkg;

    localparam int CLK_HZ = 200_000_000;
    localparam int SAMPLE_HZ = 18600;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam int CONV15_MS = 3500;
    localparam int CONV13_MS = 875;
    localparam int CONV15_SMP = SAMPLE_HZ * CONV15_MS / 1000;
    localparam int CONV13_SMP = SAMPLE_HZ * CONV13_MS / 1000;
    localparam int SLEEP_MS = 2000;
    localparam int SLEEP_CYC = CLK_HZ / 1000 * SLEEP_MS;

    localparam int CUR_BITS_HI = 15;
    localparam int ACR_FRAC_W = 12;

    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_SPECIAL = 8'h08;
    localparam logic [7:0] ADDR_CUR_MSB = 8'h0E;
    localparam logic [7:0] ADDR_CUR_LSB = 8'h0F;
    localparam logic [7:0] ADDR_ACR_MSB = 8'h10;
    localparam logic [7:0] ADDR_ACR_LSB = 8'h11;

    localparam int STAT_SLEEP_EN_BIT = 6;
    localparam int STAT_ADDR_OPC_BIT = 4;
    localparam int SPEC_IO_PIN_BIT = 6;

    localparam logic RST_SLEEP_EN = 1'b0;
    localparam logic RST_ADDR_OPC = 1'b0;
    localparam logic RST_IO_PIN_DRIVE = 1'b0;

    typedef enum logic {CCPM_SLEEP, CCPM_ACTIVE} ccpm_mode_e;
    typedef enum logic {CCPM_NORMAL_SPEED, CCPM_OVERDRIVE} ccpm_speed_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccpm_acc_s;

endpackage

// ### hw/ccpm_lowtimer.sv
`timescale 1ns/1ps
module ccpm_lowtimer
    import ccpm_pkg::*;
#(
    parameter int LIMIT = SLEEP_CYC
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic dq_in,
    input wire logic sleep_en,
    input wire logic active,
    output logic expired_q
);

    logic [31:0] count_q;
    logic [31:0] count_d;
    logic expired_d;

    always_comb
    begin
        count_d = count_q;
        expired_d = 1'b0;
        // Any high level or a cleared enable restarts the count, so only one unbroken low period counts.
        if (dq_in || !sleep_en || !active)
        begin
            count_d = 32'h0;
        end
        else if (count_q >= 32'(LIMIT - 1))
        begin
            expired_d = 1'b1;
        end
        else
        begin
            count_d = count_q + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= 32'h0;
            expired_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            expired_q <= expired_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    low_restart_a: assert property (dq_in |=> count_q == 32'h0)
        else $error("low timer did not restart on high line");
    expire_after_a: assert property (expired_q |-> $past(count_q) >= 32'(LIMIT - 1) && !$past(dq_in))
        else $error("low timer expired early");

endmodule

// ### hw/ccpm_ctrl.sv
// What this block does
// - Bus speed pin high selects overdrive timing, low selects normal speed timing.
// - A fixed unique 64-bit network address is held for device selection.
// - Current result is signed with 15-bit or 13-bit magnitude per build option.
// - Net charge flow accumulates into a separate 16-bit register.
// - Status and measurement registers are readable over the data line; status, special and accumulated charge registers are writable.
// - Active mode measures and accumulates continuously and updates registers.
// - Sleep stops measurement and accumulation but still answers register accesses.
// - Wake on data line high above undervoltage, or supply rising past threshold.
// - Undervoltage in Active forces Sleep.
// - Sleep-enable set and data line low for 2s forces Sleep.
// - Sense input sampled at 18.6kHz; result written at each conversion end except the first after an accumulator write.
// - Programmable pin is input or open-drain low output under register control.
// - Data line is only pulled low or released, and always sensed.
// - Sleep-enable bit is 0 after power-up.
// - Conversion period is 3.5s for 15-bit and 0.875s for 13-bit.
`timescale 1ns/1ps
module ccpm_ctrl
    import ccpm_pkg::*;
#(
    parameter int CUR_BITS = CUR_BITS_HI,
    parameter int SAMPLE_DIV = SAMPLE_CYC,
    parameter int CONV_SMP = (CUR_BITS == CUR_BITS_HI) ? CONV15_SMP : CONV13_SMP,
    parameter int SLEEP_LIMIT = SLEEP_CYC,
    parameter logic [63:0] NET_ADDR = 64'h0123_4567_89AB_CDEF
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic bus_speed_select,
    input wire logic dq_in,
    input wire logic dq_pull_low,
    input wire logic uv_low,
    input wire logic signed [15:0] sense_sample,
    input wire logic io_pin_in,
    input wire ccpm_acc_s acc,
    output logic dq_out_q,
    output logic dq_oe_q,
    output logic io_pin_out_q,
    output logic io_pin_oe_q,
    output ccpm_speed_e speed_q,
    output logic [63:0] net_addr_q,
    output ccpm_mode_e mode_q,
    output logic signed [15:0] current_q,
    output logic [15:0] acr_q,
    output logic [7:0] rdata_q
);

    // Averaging divides by the power of two nearest the sample count; the small gain error is traded
    // for a divider-free datapath.
    localparam int AVG_SHIFT = $clog2(CONV_SMP - CONV_SMP / 4);
    localparam logic signed [39:0] CUR_MAX = 40'sd1 <<< CUR_BITS;

    function automatic logic signed [15:0] clip(input logic signed [39:0] v);
        if (v >= CUR_MAX)
            clip = 16'(CUR_MAX - 40'sd1);
        else if (v <= -CUR_MAX)
            clip = 16'(40'sd1 - CUR_MAX);
        else
            clip = v[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic sleep_expired;
    logic sleep_en_q;
    ccpm_mode_e mode_d;
    logic uv_prev_q;

    ccpm_lowtimer #(.LIMIT(SLEEP_LIMIT)) u_lowtimer (
        .clk(clk),
        .reset_n(reset_n),
        .dq_in(dq_in),
        .sleep_en(sleep_en_q),
        .active(mode_q == CCPM_ACTIVE),
        .expired_q(sleep_expired)
    );

    always_comb
    begin
        mode_d = mode_q;
        case (mode_q)
            CCPM_ACTIVE:
            begin
                if (uv_low || sleep_expired)
                    mode_d = CCPM_SLEEP;
            end
            CCPM_SLEEP:
            begin
                if ((dq_in && !uv_low) || (uv_prev_q && !uv_low))
                    mode_d = CCPM_ACTIVE;
            end
            default: mode_d = CCPM_SLEEP;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] div_q, div_d, smp_q, smp_d;
    logic signed [39:0] sum_q, sum_d;
    logic signed [15:0] current_d;
    logic [15:0] acr_d;
    logic [ACR_FRAC_W-1:0] frac_q, frac_d;
    logic skip_q, skip_d;
    logic conv_done;
    logic [27:0] acc_sum;

    always_comb
    begin
        div_d = div_q;
        smp_d = smp_q;
        sum_d = sum_q;
        current_d = current_q;
        acr_d = acr_q;
        frac_d = frac_q;
        skip_d = skip_q;
        conv_done = 1'b0;
        acc_sum = {acr_q, frac_q} + {{12{current_d[15]}}, current_d};
        if (mode_q == CCPM_ACTIVE)
        begin
            div_d = (div_q >= 32'(SAMPLE_DIV - 1)) ? 32'h0 : div_q + 32'h1;
            if (div_q == 32'h0)
            begin
                sum_d = sum_q + 40'(sense_sample);
                smp_d = smp_q + 32'h1;
                if (smp_q >= 32'(CONV_SMP - 1))
                begin
                    conv_done = 1'b1;
                    smp_d = 32'h0;
                    sum_d = 40'sh0;
                end
            end
        end
        else
        begin
            div_d = 32'h0;
            smp_d = 32'h0;
            sum_d = 40'sh0;
        end
        if (conv_done)
        begin
            if (skip_q)
                skip_d = 1'b0;
            else
            begin
                current_d = clip((sum_q + 40'(sense_sample)) >>> AVG_SHIFT);
                acc_sum = {acr_q, frac_q} + {{12{current_d[15]}}, current_d};
                {acr_d, frac_d} = acc_sum;
            end
        end
        // A write lands after any accumulation in the same cycle; the fraction is dropped and the
        // next conversion is skipped, updating neither result nor accumulator, so only the second one is accumulated.
        if (acc.wr && (acc.addr == ADDR_ACR_MSB || acc.addr == ADDR_ACR_LSB))
        begin
            if (acc.addr == ADDR_ACR_MSB)
                acr_d = {acc.wdata, acr_q[7:0]};
            else
                acr_d = {acr_q[15:8], acc.wdata};
            frac_d = '0;
            skip_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic sleep_en_d, addr_opc_q, addr_opc_d, io_pin_oe_d;
    logic [7:0] shadow_q, shadow_d, rdata_d;

    always_comb
    begin
        sleep_en_d = sleep_en_q;
        addr_opc_d = addr_opc_q;
        io_pin_oe_d = io_pin_oe_q;
        shadow_d = shadow_q;
        rdata_d = rdata_q;
        if (acc.wr && acc.addr == ADDR_STATUS)
        begin
            sleep_en_d = acc.wdata[STAT_SLEEP_EN_BIT];
            addr_opc_d = acc.wdata[STAT_ADDR_OPC_BIT];
        end
        if (acc.wr && acc.addr == ADDR_SPECIAL)
            io_pin_oe_d = !acc.wdata[SPEC_IO_PIN_BIT];
        if (acc.rd)
        begin
            // Reading the high byte freezes the low byte so the pair stays consistent.
            case (acc.addr)
                ADDR_STATUS: rdata_d = 8'(sleep_en_q) << STAT_SLEEP_EN_BIT | 8'(addr_opc_q) << STAT_ADDR_OPC_BIT;
                ADDR_SPECIAL: rdata_d = 8'(io_pin_in) << SPEC_IO_PIN_BIT;
                ADDR_CUR_MSB:
                begin
                    rdata_d = current_q[15:8];
                    shadow_d = current_q[7:0];
                end
                ADDR_ACR_MSB:
                begin
                    rdata_d = acr_q[15:8];
                    shadow_d = acr_q[7:0];
                end
                ADDR_CUR_LSB, ADDR_ACR_LSB: rdata_d = shadow_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_q <= CCPM_ACTIVE;
            uv_prev_q <= 1'b0;
            div_q <= 32'h0;
            smp_q <= 32'h0;
            sum_q <= 40'sh0;
            current_q <= 16'sh0;
            acr_q <= 16'h0;
            frac_q <= '0;
            skip_q <= 1'b0;
            sleep_en_q <= RST_SLEEP_EN;
            addr_opc_q <= RST_ADDR_OPC;
            io_pin_oe_q <= RST_IO_PIN_DRIVE;
            io_pin_out_q <= 1'b0;
            shadow_q <= 8'h00;
            rdata_q <= 8'h00;
            dq_out_q <= 1'b0;
            dq_oe_q <= 1'b0;
            speed_q <= CCPM_NORMAL_SPEED;
            net_addr_q <= NET_ADDR;
        end
        else
        begin
            mode_q <= mode_d;
            uv_prev_q <= uv_low;
            div_q <= div_d;
            smp_q <= smp_d;
            sum_q <= sum_d;
            current_q <= current_d;
            acr_q <= acr_d;
            frac_q <= frac_d;
            skip_q <= skip_d;
            sleep_en_q <= sleep_en_d;
            addr_opc_q <= addr_opc_d;
            io_pin_oe_q <= io_pin_oe_d;
            io_pin_out_q <= 1'b0;
            shadow_q <= shadow_d;
            rdata_q <= rdata_d;
            dq_out_q <= 1'b0;
            dq_oe_q <= dq_pull_low;
            speed_q <= bus_speed_select ? CCPM_OVERDRIVE : CCPM_NORMAL_SPEED;
            net_addr_q <= NET_ADDR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence wake_cause;
        mode_q == CCPM_SLEEP && !uv_low && (dq_in || uv_prev_q);
    endsequence
    sequence timed_out;
        mode_q == CCPM_ACTIVE && sleep_expired;
    endsequence

    speed_follow_a: assert property (##1 (speed_q == CCPM_OVERDRIVE) == $past(bus_speed_select))
        else $error("bus speed does not follow select pin");
    addr_fixed_a: assert property (net_addr_q == NET_ADDR)
        else $error("network address changed");
    cur_range_a: assert property (40'(current_q) < CUR_MAX && 40'(current_q) > -CUR_MAX)
        else $error("current result exceeds resolution");
    wake_up_a: assert property (wake_cause |=> mode_q == CCPM_ACTIVE)
        else $error("device did not wake");
    uv_sleep_a: assert property (mode_q == CCPM_ACTIVE && uv_low |=> mode_q == CCPM_SLEEP)
        else $error("undervoltage did not force sleep");
    low_sleep_a: assert property (timed_out |=> mode_q == CCPM_SLEEP)
        else $error("low line timeout did not force sleep");
    sleep_hold_a: assert property (mode_q == CCPM_SLEEP |=> $stable(current_q) && smp_q == 32'h0)
        else $error("measurement ran during sleep");
    conv_only_a: assert property (!conv_done |=> $stable(current_q))
        else $error("current result changed outside conversion end");
    dq_drive_a: assert property (dq_oe_q |-> dq_out_q == 1'b0 && $past(dq_pull_low))
        else $error("data line driven other than low");
    sleep_init_a: assert property ($rose(reset_n) |-> sleep_en_q == 1'b0)
        else $error("sleep enable not clear after reset");

endmodule

// ### verification/ccpm_host_model.sv
`timescale 1ns/1ps
module ccpm_host_model
(
    input wire logic hold_low,
    input wire logic speed_cmd,
    input wire logic dev_pull_low,
    output logic dq_line,
    output logic speed_pin
);
    // The host keeps a pull-up on the line, so it reads high unless some party pulls it low.
    assign dq_line = !(hold_low || dev_pull_low);
    // One speed level feeds every device on the line, so mixed speeds cannot occur.
    assign speed_pin = speed_cmd;
endmodule

// ### verification/coulomb_counter_power_mode_ctrl_tb_top.sv
`timescale 1ns/1ps
module coulomb_counter_power_mode_ctrl_tb_top
    import ccpm_pkg::*;
;
    localparam int SDIV = 4;
    localparam int CSMP = 8;
    localparam int SLIM = 50;
    localparam int CONV = SDIV * CSMP;
    // Arbitrary address value, chosen only to differ from the default.
    localparam logic [63:0] NADDR = 64'h0F1E_2D3C_4B5A_6978;
    logic clk;
    logic reset_n;
    logic speed_cmd;
    logic speed_pin;
    logic dq_line;
    logic host_low;
    logic dq_pull_low;
    logic uv_low;
    logic signed [15:0] sense_sample;
    logic io_pin_in;
    ccpm_acc_s acc;
    logic dq_out_q;
    logic dq_oe_q;
    logic io_pin_out_q;
    logic io_pin_oe_q;
    ccpm_speed_e speed_q;
    logic [63:0] net_addr_q;
    ccpm_mode_e mode_q;
    logic signed [15:0] current_q;
    logic [15:0] acr_q;
    logic [7:0] rdata_q;
    int n_mismatch = 0;
    int n_compared = 0;
    ////////////////////////////////////////////////////////////////////////////////
    ccpm_host_model host (.hold_low(host_low), .speed_cmd(speed_cmd), .dev_pull_low(dq_oe_q),
        .dq_line(dq_line), .speed_pin(speed_pin));
    ccpm_ctrl #(.CUR_BITS(CUR_BITS_HI), .SAMPLE_DIV(SDIV), .CONV_SMP(CSMP), .SLEEP_LIMIT(SLIM),
        .NET_ADDR(NADDR)) uut (.clk(clk), .reset_n(reset_n), .bus_speed_select(speed_pin),
        .dq_in(dq_line), .dq_pull_low(dq_pull_low), .uv_low(uv_low), .sense_sample(sense_sample),
        .io_pin_in(io_pin_in), .acc(acc), .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q), .io_pin_out_q(io_pin_out_q),
        .io_pin_oe_q(io_pin_oe_q), .speed_q(speed_q), .net_addr_q(net_addr_q), .mode_q(mode_q),
        .current_q(current_q), .acr_q(acr_q), .rdata_q(rdata_q));
    ////////////////////////////////////////////////////////////////////////////////
    always #2.5 clk = ~clk;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // An idle cycle closes each access, so the next call never re-drives the port in the same time step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        cyc(1);
        acc = '0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        acc = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        cyc(1);
        acc = '0;
        d = rdata_q;
        cyc(1);
    endtask

    // Averaging equal samples gives the sample back, clipped to the symmetric magnitude limit.
    function automatic logic signed [15:0] exp_cur(input int v);
        int lim;
        lim = (1 << CUR_BITS_HI) - 1;
        if (v > lim) v = lim;
        if (v < -lim) v = -lim;
        return 16'(v);
    endfunction

    task automatic tally_and_finish;
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] d;
        logic [15:0] a0;
        logic [15:0] c0;
        int vals[4];
        int n;
        clk = 0;
        reset_n = 0;
        speed_cmd = 0;
        host_low = 0;
        dq_pull_low = 0;
        uv_low = 0;
        sense_sample = 0;
        io_pin_in = 0;
        acc = '0;
        void'($urandom(76552));
        cyc(10);
        chk(net_addr_q, NADDR);
        reset_n = 1;
        rd(ADDR_STATUS, d);
        chk(d[STAT_SLEEP_EN_BIT], 1'b0);
        rd(8'h05, d);
        chk(d, 8'h00);
        repeat (20)
        begin
            speed_cmd = 1'($urandom);
            dq_pull_low = 1'($urandom);
            cyc(1);
            chk(speed_q, speed_cmd);
            chk({dq_oe_q, dq_out_q}, {dq_pull_low, 1'b0});
        end
        dq_pull_low = 0;
        for (int b = 0; b < 2; b++)
        begin
            // A pin pulled low by the block reads back low, as the real pin would.
            io_pin_in = b ? 1'($urandom) : 1'b0;
            wr(ADDR_SPECIAL, 8'(b << SPEC_IO_PIN_BIT));
            chk({io_pin_oe_q, io_pin_out_q}, {~1'(b), 1'b0});
            rd(ADDR_SPECIAL, d);
            chk(d[SPEC_IO_PIN_BIT], io_pin_in);
        end
        vals = '{int'($signed(16'($urandom))), 32767, -32768, 16384};
        foreach (vals[i])
        begin
            sense_sample = 16'(vals[i]);
            cyc(3 * CONV + 4);
            chk(current_q, exp_cur(vals[i]));
        end
        wr(ADDR_ACR_MSB, 8'h01);
        wr(ADDR_ACR_LSB, 8'h00);
        chk(acr_q, 16'h0100);
        cyc(10 * CONV);
        a0 = acr_q - 16'h0100;
        chk(a0[1:0] == 2'b00 && a0 >= 28 && a0 <= 40, 1'b1);
        ////////////////////////////////////////////////////////////////////////////
        host_low = 1;
        uv_low = 1;
        cyc(1);
        chk(mode_q, CCPM_SLEEP);
        a0 = acr_q;
        c0 = current_q;
        sense_sample = -16'sd1000;
        cyc(4 * CONV);
        chk({current_q, acr_q}, {c0, a0});
        rd(ADDR_CUR_MSB, d);
        chk(d, c0[15:8]);
        wr(ADDR_CUR_LSB, 8'hFF);
        rd(ADDR_CUR_LSB, d);
        chk(d, c0[7:0]);
        uv_low = 0;
        cyc(1);
        chk(mode_q, CCPM_ACTIVE);
        cyc(2 * SLIM);
        chk(mode_q, CCPM_ACTIVE);
        host_low = 0;
        wr(ADDR_STATUS, 8'h50);
        rd(ADDR_STATUS, d);
        chk(d[STAT_SLEEP_EN_BIT], 1'b1);
        chk(d[STAT_ADDR_OPC_BIT], 1'b1);
        host_low = 1;
        cyc(SLIM - 10);
        host_low = 0;
        cyc(1);
        host_low = 1;
        cyc(SLIM - 10);
        chk(mode_q, CCPM_ACTIVE);
        wr(ADDR_STATUS, 8'h00);
        wr(ADDR_STATUS, 8'h40);
        cyc(SLIM - 10);
        chk(mode_q, CCPM_ACTIVE);
        host_low = 0;
        cyc(1);
        host_low = 1;
        cyc(SLIM - 3);
        chk(mode_q, CCPM_ACTIVE);
        n = 0;
        while (mode_q !== CCPM_SLEEP && n < 8)
        begin
            cyc(1);
            n++;
        end
        chk(mode_q, CCPM_SLEEP);
        host_low = 0;
        cyc(1);
        chk(mode_q, CCPM_ACTIVE);
        tally_and_finish();
    end

    // The whole sequence needs under two thousand cycles; the limit leaves ample slack.
    initial
    begin
        #(20000 * 5);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
